// *** hdl/cds_ctrl_bank.sv ***
// Purpose: Card control and device control registers for two socket functions
// Assumes: One clock, synchronous active-low reset, AHB-Lite register access
// Notes:   Function 1 space sits at byte address bit 10
`timescale 1ns/1ps
`include "cds_regs.svh"
module cds_ctrl_bank
   import cds_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire cds_ahb_req_s ahb,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   input  wire logic         ring_indicate_src,
   input  wire logic         ring_pin_select,
   output logic              ring_to_pme_pin,
   output logic              ring_to_mfunc,
   output logic [1:0]        video_port_hiz,
   output logic              video_grant_socket0,
   output logic              video_grant_socket1,
   input  wire logic [1:0]   cardbus_audio_in,
   output logic              audio_pwm_output,
   input  wire logic [1:0]   card_speaker,
   output logic              speaker_output_pin,
   output logic              speaker_output_pin_oe_n,
   input  wire logic [1:0]   card_func_irq,
   input  wire logic [1:0]   socket_power_off_req,
   input  wire logic         d3_state,
   output logic [1:0]        socket_power_off_ok,
   output logic              socket_3v_capable,
   output logic [3:0]        int_signal_mode
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus front end

   logic        wr_stb;
   logic        rd_stb;
   logic [31:0] acc_addr;
   logic [7:0]  wdata;
   logic [7:0]  rd_word;

   cds_ahb_port u_port (
      .clk       (clk),
      .rstn      (rstn),
      .ahb       (ahb),
      .rd_word   (rd_word),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .wr_stb    (wr_stb),
      .rd_stb    (rd_stb),
      .acc_addr  (acc_addr),
      .wdata     (wdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State

   cds_regs_s r;
   cds_regs_s next_r;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic       addr_ok;
   logic       func_sel;
   logic [7:0] reg_idx;

   // Unmapped addresses read zero and swallow writes
   assign addr_ok  = (acc_addr[31:11] == 21'h000000) && (acc_addr[1:0] == 2'h0);
   assign func_sel = acc_addr[`CDS_FUNC_BIT];
   assign reg_idx  = acc_addr[`CDS_IDX_MSB:`CDS_IDX_LSB];

   logic [1:0] cc_hit;
   logic [1:0] dc_hit;
   logic [7:0] cc_view [2];
   logic [7:0] dc_view [2];

   ////////////////////////////////////////////////////////////////////////////
   // Per-function views

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_func
         logic fsel;

         assign fsel       = addr_ok && (func_sel == 1'(gi));
         assign cc_hit[gi] = fsel && (reg_idx == `CDS_CARD_CTRL_IDX);
         assign dc_hit[gi] = fsel && (reg_idx == `CDS_DEV_CTRL_IDX);

         // Shared bits show the one global copy in both functions
         assign cc_view[gi] = {
            r.ring_en,
            r.video_en[gi],
            r.prio[gi],
            2'b00,
            r.audio_en[gi],
            r.card_speaker_en[gi],
            r.irq_flag[gi]
         };

         assign dc_view[gi] = {
            r.pwr_lock[gi],
            r.force3v,
            r.diag_io[gi],
            1'b0,
            r.test_bit,
            r.int_mode[2*gi+1],
            r.int_mode[2*gi],
            r.test_rw
         };
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      if (rd_stb && cc_hit[0]) begin
         rd_word = cc_view[0];
      end else if (rd_stb && cc_hit[1]) begin
         rd_word = cc_view[1];
      end else if (rd_stb && dc_hit[0]) begin
         rd_word = dc_view[0];
      end else if (rd_stb && dc_hit[1]) begin
         rd_word = dc_view[1];
      end else begin
         rd_word = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic       spk0;
   logic       spk1;
   logic [1:0] irq_clr;

   always_comb begin
      next_r  = r;
      spk0    = 1'b0;
      spk1    = 1'b0;
      irq_clr = 2'b00;

      for (int i = 0; i < 2; i++) begin
         // Card control writes
         if (wr_stb && cc_hit[i]) begin
            next_r.video_en[i] = wdata[`CDS_CC_VIDEO];
            next_r.prio[i]     = wdata[`CDS_CC_PRIO];
            next_r.audio_en[i] = wdata[`CDS_CC_AUDIO];
            next_r.card_speaker_en[i]  = wdata[`CDS_CC_CARD_SPEAKER];
            if (i == 0) begin
               next_r.ring_en = wdata[`CDS_CC_RING];
            end
            irq_clr[i] = wdata[`CDS_CC_IRQ];
         end

         // Device control writes
         if (wr_stb && dc_hit[i]) begin
            next_r.pwr_lock[i]       = wdata[`CDS_DC_LOCK];
            next_r.diag_io[i]        = wdata[`CDS_DC_DIAG];
            next_r.int_mode[2*i+1]   = wdata[`CDS_DC_MODE_HI];
            next_r.int_mode[2*i]     = wdata[`CDS_DC_MODE_LO];
            // Function 1 cannot touch global bits
            if (i == 0) begin
               next_r.force3v  = wdata[`CDS_DC_3V];
               next_r.test_bit = wdata[`CDS_DC_TEST];
               next_r.test_rw  = wdata[`CDS_DC_TESTRW];
            end
         end

         // Event set beats a same-cycle clear
         next_r.irq_flag[i] = card_func_irq[i] | (r.irq_flag[i] & ~irq_clr[i]);

         // Power removal held off under lock in D3
         next_r.pwr_off_ok[i] = socket_power_off_req[i] & ~(r.pwr_lock[i] & d3_state);

         next_r.video_hiz[i] = r.video_en[i];
      end

      // Ring routes
      next_r.ring_pme   = r.ring_en & ~ring_pin_select & ring_indicate_src;
      next_r.ring_mfunc = r.ring_en & ring_indicate_src;

      // Video grant; function 0 copy of priority decides a tie
      next_r.grant0 = r.video_en[0] & (~r.video_en[1] | ~r.prio[0]);
      next_r.grant1 = r.video_en[1] & (~r.video_en[0] | r.prio[0]);

      // Audio mux, socket 0 first
      if (r.audio_en[0]) begin
         next_r.audio_out = cardbus_audio_in[0];
      end else if (r.audio_en[1]) begin
         next_r.audio_out = cardbus_audio_in[1];
      end else begin
         next_r.audio_out = 1'b0;
      end

      // Speaker: each socket gated by its own enable, then combined
      spk0 = card_speaker[0] & r.card_speaker_en[0];
      spk1 = card_speaker[1] & r.card_speaker_en[1];
      next_r.card_speaker_out  = spk0 ^ spk1;
      next_r.card_speaker_oe_n = ~(r.card_speaker_en[0] | r.card_speaker_en[1]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk) begin
      if (!rstn) begin
         r            <= '0;
         r.force3v    <= 1'(`CDS_DC_RESET >> `CDS_DC_3V);
         r.diag_io    <= {2{1'(`CDS_DC_RESET >> `CDS_DC_DIAG)}};
         r.int_mode   <= {2{`CDS_MODE_RESET}};
         r.card_speaker_oe_n  <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign ring_to_pme_pin         = r.ring_pme;
   assign ring_to_mfunc           = r.ring_mfunc;
   assign video_port_hiz          = r.video_hiz;
   assign video_grant_socket0     = r.grant0;
   assign video_grant_socket1     = r.grant1;
   assign audio_pwm_output        = r.audio_out;
   assign speaker_output_pin      = r.card_speaker_out;
   assign speaker_output_pin_oe_n = r.card_speaker_oe_n;
   assign socket_power_off_ok     = r.pwr_off_ok;
   assign socket_3v_capable       = r.force3v;
   assign int_signal_mode         = r.int_mode;

endmodule

// *** include/cds_regs.svh ***
// Purpose: Register offsets, field positions and reset values of the card/device control bank
// Assumes: Byte address = {function, index, 2'b00}
// Notes:   Definitions only
`ifndef CDS_REGS_SVH
`define CDS_REGS_SVH

// Register indices within one function's space
`define CDS_CARD_CTRL_IDX 8'h91
`define CDS_DEV_CTRL_IDX  8'h92

// Byte address layout
`define CDS_FUNC_BIT      10
`define CDS_IDX_MSB       9
`define CDS_IDX_LSB       2

// Card control fields
`define CDS_CC_RING       7
`define CDS_CC_VIDEO      6
`define CDS_CC_PRIO       5
`define CDS_CC_AUDIO      2
`define CDS_CC_CARD_SPEAKER       1
`define CDS_CC_IRQ        0

// Device control fields
`define CDS_DC_LOCK       7
`define CDS_DC_3V         6
`define CDS_DC_DIAG       5
`define CDS_DC_TEST       3
`define CDS_DC_MODE_HI    2
`define CDS_DC_MODE_LO    1
`define CDS_DC_TESTRW     0

// Reset values
`define CDS_CC_RESET      8'h00
`define CDS_DC_RESET      8'h66
`define CDS_MODE_RESET    2'h3

`endif

// *** include/cds_pkg.sv ***
// Purpose: Types shared by the card/device control bank
// Assumes: AHB-Lite single word transfers
// Notes:   Constants live in cds_regs.svh
package cds_pkg;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } cds_ahb_req_s;

   typedef enum logic [3:0] {
      CDS_P_IDLE  = 4'h1,
      CDS_P_WDATA = 4'h2,
      CDS_P_RWAIT = 4'h4,
      CDS_P_RDATA = 4'h8
   } cds_port_e;

   typedef struct packed {
      cds_port_e   st;
      logic [31:0] addr;
      logic [31:0] hrdata;
   } cds_port_s;

   typedef struct packed {
      logic       ring_en;
      logic [1:0] video_en;
      logic [1:0] prio;
      logic [1:0] audio_en;
      logic [1:0] card_speaker_en;
      logic [1:0] irq_flag;
      logic [1:0] pwr_lock;
      logic [1:0] diag_io;
      logic [3:0] int_mode;
      logic       force3v;
      logic       test_bit;
      logic       test_rw;
      logic       ring_pme;
      logic       ring_mfunc;
      logic [1:0] video_hiz;
      logic       grant0;
      logic       grant1;
      logic       audio_out;
      logic       card_speaker_out;
      logic       card_speaker_oe_n;
      logic [1:0] pwr_off_ok;
   } cds_regs_s;

endpackage

// *** hdl/cds_ahb_port.sv ***
// Purpose: AHB-Lite slave front end for the control bank
// Assumes: Single word transfers; response always OKAY
// Notes:   Writes need no wait; reads take one wait state
`timescale 1ns/1ps
module cds_ahb_port
   import cds_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire cds_ahb_req_s ahb,
   input  wire logic [7:0]   rd_word,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   output logic              wr_stb,
   output logic              rd_stb,
   output logic [31:0]       acc_addr,
   output logic [7:0]        wdata
);

   cds_port_s s;
   cds_port_s next_s;
   logic      take;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      take   = ahb.hsel & ahb.hready & ahb.htrans[1];
      case (s.st)
         CDS_P_RWAIT: begin
            // Wait state lets a preceding write settle before sampling
            next_s.hrdata = {24'h000000, rd_word};
            next_s.st     = CDS_P_RDATA;
         end
         default: begin
            if (take) begin
               next_s.addr = ahb.haddr;
               next_s.st   = ahb.hwrite ? CDS_P_WDATA : CDS_P_RWAIT;
            end else begin
               next_s.st = CDS_P_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s <= '{st: CDS_P_IDLE, addr: 32'h00000000, hrdata: 32'h00000000};
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign hreadyout = (s.st != CDS_P_RWAIT);
   assign hrdata    = s.hrdata;
   assign hresp     = 1'b0;
   assign wr_stb    = (s.st == CDS_P_WDATA);
   assign rd_stb    = (s.st == CDS_P_RWAIT);
   assign acc_addr  = s.addr;
   assign wdata     = ahb.hwdata[7:0];

endmodule

// *** test/cds_ctrl_bank_props.sv ***
// Purpose: Port-level checks of the card/device control bank
// Assumes: Registered outputs lag their causes by one clock
// Notes:   Reads take one wait state, writes none
`timescale 1ns/1ps
module cds_ctrl_bank_props
   import cds_pkg::*;
(
   input wire logic         clk,
   input wire logic         rstn,
   input wire cds_ahb_req_s ahb,
   input wire logic         hreadyout,
   input wire logic [31:0]  hrdata,
   input wire logic         ring_to_pme_pin,
   input wire logic         ring_to_mfunc,
   input wire logic         ring_indicate_src,
   input wire logic         ring_pin_select,
   input wire logic [1:0]   video_port_hiz,
   input wire logic         video_grant_socket0,
   input wire logic         video_grant_socket1,
   input wire logic [1:0]   cardbus_audio_in,
   input wire logic         audio_pwm_output,
   input wire logic [1:0]   card_speaker,
   input wire logic         speaker_output_pin,
   input wire logic         speaker_output_pin_oe_n,
   input wire logic [1:0]   socket_power_off_req,
   input wire logic [1:0]   socket_power_off_ok
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////
   a_ring_pme_path: assert property (ring_to_pme_pin |-> ring_to_mfunc)
      else $error("ring pin active without multifunction route");
   a_ring_pin_cause: assert property (ring_to_pme_pin |-> $past(ring_indicate_src) && !$past(ring_pin_select))
      else $error("ring pin active without source or with other pin chosen");
   a_grant_single: assert property (video_grant_socket0 |-> video_port_hiz[0] && !video_grant_socket1)
      else $error("socket 0 grant without its video enable or with both grants");
   a_reserved_zero: assert property (hreadyout |-> hrdata[31:8] == 24'h0 && !hrdata[4])
      else $error("reserved read bits not zero");
   a_audio_cause: assert property (audio_pwm_output |-> $past(cardbus_audio_in) != 2'b00)
      else $error("audio output high with both socket audio low");
   a_speaker_cause: assert property (speaker_output_pin |-> !speaker_output_pin_oe_n && $past(card_speaker) != 2'b00)
      else $error("speaker pin high while undriven or without a speaker");
   a_power_cause: assert property (socket_power_off_ok[0] |-> $past(socket_power_off_req[0]))
      else $error("power removal granted without request");
   a_read_wait: assert property (ahb.hsel && ahb.htrans[1] && !ahb.hwrite && ahb.hready |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   a_write_nowait: assert property (ahb.hsel && ahb.htrans[1] && ahb.hwrite && ahb.hready |=> hreadyout)
      else $error("write data phase stalled");
   c_read: cover property (!hreadyout ##1 hreadyout);
   c_grant1: cover property (video_grant_socket1);
   c_spk: cover property (!speaker_output_pin_oe_n);
   c_lock: cover property (socket_power_off_req[0] && !socket_power_off_ok[0]);
endmodule

bind cds_ctrl_bank cds_ctrl_bank_props cds_ctrl_bank_props_inst (.clk, .rstn, .ahb, .hreadyout, .hrdata,
   .ring_to_pme_pin, .ring_to_mfunc, .ring_indicate_src, .ring_pin_select, .video_port_hiz, .video_grant_socket0,
   .video_grant_socket1, .cardbus_audio_in, .audio_pwm_output, .card_speaker, .speaker_output_pin,
   .speaker_output_pin_oe_n, .socket_power_off_req, .socket_power_off_ok);

// *** test/cds_socket_model.sv ***
// Purpose: Two card sockets facing the control bank
// Assumes: Cards move their lines one clock after the bench asks
// Notes:   Lines low in reset, as an empty socket would leave them
`timescale 1ns/1ps
module cds_socket_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] irq_cmd,
   input  wire logic [1:0] spk_cmd,
   input  wire logic [1:0] aud_cmd,
   input  wire logic       ring_cmd,
   output logic [1:0]      card_func_irq,
   output logic [1:0]      card_speaker,
   output logic [1:0]      cardbus_audio_in,
   output logic            ring_indicate_src
);
   // Functional interrupt, speaker tone, audio and ring from the cards
   always_ff @(posedge clk) begin
      if (!rstn) begin
         {card_func_irq, card_speaker, cardbus_audio_in, ring_indicate_src} <= 7'h00;
      end else begin
         {card_func_irq, card_speaker, cardbus_audio_in, ring_indicate_src} <= {irq_cmd, spk_cmd, aud_cmd, ring_cmd};
      end
   end
endmodule

// *** test/testbench.sv ***
// Purpose: Register and pin scenarios for the card/device control bank
// Assumes: Function 1 space at byte address bit 10
// Notes:   Bench writes only zero to the test bits of device control
`timescale 1ns/1ps
module testbench;
   import cds_pkg::*;
   localparam logic [31:0] CC0 = 32'h244, DC0 = 32'h248, CC1 = 32'h644, DC1 = 32'h648;
   logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, ring_pin_select = 0, d3_state = 0, ring_cmd = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rdata;
   logic [1:0]  htrans = 0, irq_cmd = 0, spk_cmd = 0, aud_cmd = 0, socket_power_off_req = 0;
   logic [1:0]  card_func_irq, card_speaker, cardbus_audio_in, video_port_hiz, socket_power_off_ok;
   logic        hreadyout, hresp, ring_indicate_src, ring_to_pme_pin, ring_to_mfunc, video_grant_socket0;
   logic        video_grant_socket1, audio_pwm_output, speaker_output_pin, speaker_output_pin_oe_n, socket_3v_capable;
   logic [3:0]  int_signal_mode;
   int          failures = 0, tests_run = 0;
   wire cds_ahb_req_s ahb = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout};
   always #4 clk = ~clk;
   cds_socket_model cds_socket_model_inst (.clk, .rstn, .irq_cmd, .spk_cmd, .aud_cmd, .ring_cmd, .card_func_irq,
      .card_speaker, .cardbus_audio_in, .ring_indicate_src);
   cds_ctrl_bank cds_ctrl_bank_inst (.clk, .rstn, .ahb, .hreadyout, .hrdata, .hresp, .ring_indicate_src,
      .ring_pin_select, .ring_to_pme_pin, .ring_to_mfunc, .video_port_hiz, .video_grant_socket0,
      .video_grant_socket1, .cardbus_audio_in, .audio_pwm_output, .card_speaker, .speaker_output_pin,
      .speaker_output_pin_oe_n, .card_func_irq, .socket_power_off_req, .d3_state, .socket_power_off_ok,
      .socket_3v_capable, .int_signal_mode);
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (failures == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Sample ready half a cycle early; it only moves at rising edges
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      rdata = hrdata;
      if (n >= 20) begin
         failures++;
         tally_and_finish();
      end
      @(posedge clk);
   endtask
   task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
      bus(a, 1'b0, 8'h00);
      chk($sformatf("reg %h", a), rdata, {24'h0, exp});
   endtask
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(CC0, 8'h00);
      rd_chk(DC0, 8'h66);
      rd_chk(DC1, 8'h66);
      chk("cap3v", 32'(socket_3v_capable), 1);
      chk("mode", 32'(int_signal_mode), 32'hf);
      bus(CC0, 1'b1, 8'hff);
      rd_chk(CC0, 8'he6);
      rd_chk(CC1, 8'h80);
      bus(CC1, 1'b1, 8'h42);
      rd_chk(CC0, 8'he6);
      rd_chk(CC1, 8'hc2);
      @(posedge clk);
      ring_cmd <= 1'b1;
      spk_cmd <= 2'b01;
      aud_cmd <= 2'b01;
      settle();
      chk("hiz", 32'(video_port_hiz), 3);
      chk("grant", 32'({video_grant_socket1, video_grant_socket0}), 2);
      chk("ring", 32'({ring_to_pme_pin, ring_to_mfunc}), 3);
      chk("spk", 32'({speaker_output_pin_oe_n, speaker_output_pin}), 1);
      chk("aud", 32'(audio_pwm_output), 1);
      @(posedge clk);
      ring_pin_select <= 1'b1;
      spk_cmd <= 2'b11;
      aud_cmd <= 2'b10;
      bus(CC1, 1'b1, 8'h46);
      settle();
      chk("ring", 32'({ring_to_pme_pin, ring_to_mfunc}), 1);
      chk("spk", 32'({speaker_output_pin_oe_n, speaker_output_pin}), 0);
      chk("aud", 32'(audio_pwm_output), 0);
      bus(CC0, 1'b1, 8'h46);
      settle();
      chk("grant", 32'({video_grant_socket1, video_grant_socket0}), 1);
      chk("ring", 32'({ring_to_pme_pin, ring_to_mfunc}), 0);
      bus(CC1, 1'b1, 8'h00);
      settle();
      chk("spk", 32'({speaker_output_pin_oe_n, speaker_output_pin}), 1);
      bus(CC0, 1'b1, 8'h00);
      settle();
      chk("spk", 32'({speaker_output_pin_oe_n, speaker_output_pin}), 2);
      @(posedge clk);
      irq_cmd <= 2'b10;
      @(posedge clk);
      irq_cmd <= 2'b00;
      rd_chk(CC1, 8'h01);
      rd_chk(CC0, 8'h00);
      bus(CC1, 1'b1, 8'h00);
      rd_chk(CC1, 8'h01);
      // Event lands on the clearing write's edge only
      fork
         bus(CC1, 1'b1, 8'h01);
         begin
            @(posedge clk);
            irq_cmd <= 2'b10;
            @(posedge clk);
            irq_cmd <= 2'b00;
         end
      join
      rd_chk(CC1, 8'h01);
      irq_cmd <= 2'b00;
      bus(CC1, 1'b1, 8'h01);
      rd_chk(CC1, 8'h00);
      for (int m = 0; m < 4; m++) begin
         bus(DC0, 1'b1, 8'h10 | 8'(m << 1));
         rd_chk(DC0, 8'(m << 1));
         chk("mode", 32'(int_signal_mode), 32'hc | 32'(m));
      end
      chk("cap3v", 32'(socket_3v_capable), 0);
      bus(DC0, 1'b1, 8'h80);
      @(posedge clk);
      d3_state <= 1'b1;
      socket_power_off_req <= 2'b11;
      settle();
      chk("pwr", 32'(socket_power_off_ok), 2);
      @(posedge clk);
      d3_state <= 1'b0;
      settle();
      chk("pwr", 32'(socket_power_off_ok), 3);
      rd_chk(32'h24c, 8'h00);
      chk("resp", 32'(hresp), 0);
      tally_and_finish();
   end
endmodule
